// ===== logic/pickup_pkg.sv
package pickup_pkg;

    // ****************************************************************
    // register map (word addresses are byte offsets, 32-bit words)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    localparam logic [7:0] ADDR_EVENT = 8'h1C;
    localparam logic [7:0] ADDR_FAULT = 8'h20;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int CTRL_UNDER_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_DTYPE_LSB = 3;
    localparam int CTRL_PHASE_BIT = 4;
    localparam int CTRL_REC_BIT = 5;
    localparam int CTRL_OBJ_LSB = 8;
    localparam int CTRL_EDIT_BIT = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // command register bits (self clearing)
    localparam int CMD_LATCH_BIT = 0;
    localparam int CMD_FAULT_BIT = 1;

    // interrupt / status event bits
    localparam int EV_START = 0;
    localparam int EV_BLOCKED = 1;
    localparam int EV_TRIP = 2;
    localparam int EV_W = 3;

    // ****************************************************************
    // measurement and timing
    // ****************************************************************
    localparam int MEAS_W = 16;
    localparam int HYST_PERCENT = 97;
    localparam logic [MEAS_W-1:0] LEVEL_RESET = 16'h0100;
    localparam int CLK_HZ = 10_000_000;
    localparam int DELAY_STEP_US = 5000;
    localparam int DELAY_W = 19;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 19'h0_0008; // 8 steps = 0.040 s
    localparam int OBJ_COUNT = 10;
    localparam logic [3:0] OBJ_RESET = 4'h0;

    typedef enum logic [1:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED} dev_mode_e;
    typedef enum logic {DTYPE_DEFINITE, DTYPE_INSTANT} delay_type_e;

endpackage

// ===== logic/pickup_stage.sv
`timescale 1ns/1ps
// Operation
// - compare measurement with pick-up level each cycle, pick up in monitored direction
// - release only when measurement returns past 97 percent of level, 103 percent for under stage
// - sample blocking input once per processing cycle, hold for decisions
// - pick-up without blocking asserts start and runs operate timing
// - pick-up with blocking asserts blocked instead, no operate timing
// - blocking after start drops start and resets timing like release
// - each blocking occurrence records timestamped event with values and fault type
// - latch reset command clears latched signals, then self-returns idle
// - latch reset input clears latched signals like panel acknowledge
// - fault record reset input clears latest fault register
// - phase order input low means A-B-C, high means A-C-B, swapped when control phase bit is set
// - device mode on/blocked/test/test-blocked, default on, edit only when permitted
// - push-button lamps follow one of ten selectable objects, default first
// - measurement recorder enable defaults off and gates recording
// - instant mode trips in same cycle start is asserted
// - definite time trips after delay in 5 ms steps, default 40 ms
module pickup_stage (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // measurement datapath
    input wire logic cycle_start_i,
    input wire logic [pickup_pkg::MEAS_W-1:0] meas_i,
    input wire logic [7:0] fault_type_i,
    // logical inputs from pins
    input wire logic block_i,
    input wire logic latch_reset_i,
    input wire logic fault_reset_i,
    input wire logic phase_order_i,
    input wire logic edit_allow_i,
    input wire logic [pickup_pkg::OBJ_COUNT-1:0] obj_closed_i,
    // indications
    output logic start_o,
    output logic blocked_o,
    output logic trip_o,
    output logic latched_trip_o,
    output logic blocked_notify_o,
    output logic phase_acb_o,
    output logic rec_enable_o,
    output logic lamp_close_o,
    output logic lamp_open_o,
    output logic irq_o
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // three stage synchroniser with agreement of the last two stages
    function automatic logic agree(input logic [2:0] s, input logic prev);
        agree = (s[2] == s[1]) ? s[2] : prev;
    endfunction

    // byte lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] blk_s_q, lrs_s_q, frs_s_q, ph_s_q, ed_s_q;
    logic blk_q, lrs_q, frs_q, ph_q, ed_q;

    // first stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            blk_s_q <= '0;
            lrs_s_q <= '0;
            frs_s_q <= '0;
            ph_s_q <= '0;
            ed_s_q <= '0;
        end else begin
            blk_s_q <= {blk_s_q[1:0], block_i};
            lrs_s_q <= {lrs_s_q[1:0], latch_reset_i};
            frs_s_q <= {frs_s_q[1:0], fault_reset_i};
            ph_s_q <= {ph_s_q[1:0], phase_order_i};
            ed_s_q <= {ed_s_q[1:0], edit_allow_i};
        end
    end

    // filtered levels
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            blk_q <= 1'b0;
            lrs_q <= 1'b0;
            frs_q <= 1'b0;
            ph_q <= 1'b0;
            ed_q <= 1'b0;
        end else begin
            blk_q <= agree(blk_s_q, blk_q);
            lrs_q <= agree(lrs_s_q, lrs_q);
            frs_q <= agree(frs_s_q, frs_q);
            ph_q <= agree(ph_s_q, ph_q);
            ed_q <= agree(ed_s_q, ed_q);
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] ctrl_q, ctrl_wr;
    logic [pickup_pkg::MEAS_W-1:0] level_q;
    logic [pickup_pkg::DELAY_W-1:0] delay_q;
    logic [pickup_pkg::EV_W-1:0] int_stat_q, int_mask_q;
    logic [31:0] event_q, fault_q;
    logic cmd_latch_q, cmd_fault_q;
    logic wr_en, rd_en;
    logic [pickup_pkg::EV_W-1:0] ev_set;
    pickup_pkg::dev_mode_e mode;
    logic under;

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign under = ctrl_q[pickup_pkg::CTRL_UNDER_BIT];
    assign mode = pickup_pkg::dev_mode_e'(ctrl_q[pickup_pkg::CTRL_MODE_LSB +: 2]);
    assign ctrl_wr = merge(ctrl_q, wb_dat_i, wb_sel_i);

    // control: mode field only changes while editing is permitted
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= pickup_pkg::CTRL_RESET;
        end else if (wr_en && wb_adr_i == pickup_pkg::ADDR_CTRL) begin
            ctrl_q <= ctrl_wr;
            if (!ed_q) begin
                ctrl_q[pickup_pkg::CTRL_MODE_LSB +: 2] <= ctrl_q[pickup_pkg::CTRL_MODE_LSB +: 2];
            end
            if (ctrl_wr[pickup_pkg::CTRL_OBJ_LSB +: 4] >= 4'(pickup_pkg::OBJ_COUNT)) begin
                ctrl_q[pickup_pkg::CTRL_OBJ_LSB +: 4] <= ctrl_q[pickup_pkg::CTRL_OBJ_LSB +: 4];
            end
        end
    end

    // level and delay settings
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            level_q <= pickup_pkg::LEVEL_RESET;
            delay_q <= pickup_pkg::DELAY_RESET;
        end else if (wr_en && wb_adr_i == pickup_pkg::ADDR_LEVEL) begin
            level_q <= (pickup_pkg::MEAS_W)'(merge({16'h0000, level_q}, wb_dat_i, wb_sel_i));
        end else if (wr_en && wb_adr_i == pickup_pkg::ADDR_DELAY) begin
            delay_q <= (pickup_pkg::DELAY_W)'(merge({13'h0000, delay_q}, wb_dat_i, wb_sel_i));
        end
    end

    // command bits return to idle on the next cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cmd_latch_q <= 1'b0;
            cmd_fault_q <= 1'b0;
        end else begin
            cmd_latch_q <= wr_en && wb_adr_i == pickup_pkg::ADDR_CMD && wb_sel_i[0]
                && wb_dat_i[pickup_pkg::CMD_LATCH_BIT];
            cmd_fault_q <= wr_en && wb_adr_i == pickup_pkg::ADDR_CMD && wb_sel_i[0]
                && wb_dat_i[pickup_pkg::CMD_FAULT_BIT];
        end
    end

    // interrupt status: set wins over write-one-to-clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            int_stat_q <= '0;
            int_mask_q <= '0;
        end else begin
            if (wr_en && wb_adr_i == pickup_pkg::ADDR_INT_STAT && wb_sel_i[0]) begin
                int_stat_q <= (int_stat_q & ~wb_dat_i[pickup_pkg::EV_W-1:0]) | ev_set;
            end else begin
                int_stat_q <= int_stat_q | ev_set;
            end
            if (wr_en && wb_adr_i == pickup_pkg::ADDR_INT_MASK && wb_sel_i[0]) begin
                int_mask_q <= wb_dat_i[pickup_pkg::EV_W-1:0];
            end
        end
    end

    // ****************************************************************
    // pick-up decision, once per processing cycle
    // ****************************************************************
    logic pickup_q, blk_cyc_q, tmr_expired;
    logic [31:0] stamp_q;
    logic [pickup_pkg::MEAS_W+7:0] meas_x100, lvl_x100, lvl_x97;
    logic over_set, past_reset, pick_d, blk_eff, run_tmr, instant;

    assign meas_x100 = (pickup_pkg::MEAS_W+8)'(meas_i) * 24'd100;
    assign lvl_x100 = (pickup_pkg::MEAS_W+8)'(level_q) * 24'd100;
    assign lvl_x97 = (pickup_pkg::MEAS_W+8)'(level_q) * 24'(pickup_pkg::HYST_PERCENT);
    // over stage resets below 97 %, under stage resets above 103 % (mirrored)
    assign over_set = under ? (meas_i < level_q) : (meas_i > level_q);
    assign past_reset = under ? (meas_x100 > (lvl_x100 << 1) - lvl_x97)
                              : (meas_x100 < lvl_x97);
    assign pick_d = pickup_q ? !past_reset : over_set;
    assign blk_eff = blk_q || mode == pickup_pkg::MODE_BLOCKED || mode == pickup_pkg::MODE_TEST_BLOCKED;
    assign instant = ctrl_q[pickup_pkg::CTRL_DTYPE_LSB] || delay_q == '0;
    assign run_tmr = pickup_q && !blk_cyc_q && !instant;

    // free running timestamp for event records
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stamp_q <= '0;
        end else begin
            stamp_q <= stamp_q + 1'b1;
        end
    end

    // pick-up element and blocking sample; blocking held for the whole cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pickup_q <= 1'b0;
            blk_cyc_q <= 1'b0;
        end else if (cycle_start_i) begin
            pickup_q <= pick_d;
            blk_cyc_q <= blk_eff;
        end
    end

    step_timer u_timer (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(run_tmr),
        .steps_i(delay_q),
        .expired_o(tmr_expired)
    );

    // indications: start and blocked exclusive, trip follows start
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            start_o <= 1'b0;
            blocked_o <= 1'b0;
            trip_o <= 1'b0;
        end else if (cycle_start_i) begin
            start_o <= pick_d && !blk_eff;
            blocked_o <= pick_d && blk_eff;
            trip_o <= pick_d && !blk_eff && (instant || (run_tmr && tmr_expired));
        end
    end

    assign ev_set = {cycle_start_i && pick_d && !blk_eff && (instant || (run_tmr && tmr_expired)) && !trip_o,
                     cycle_start_i && pick_d && blk_eff && !blocked_o,
                     cycle_start_i && pick_d && !blk_eff && !start_o};

    // blocking event record and display notice, one per new blocking
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            event_q <= '0;
            blocked_notify_o <= 1'b0;
        end else begin
            blocked_notify_o <= ev_set[pickup_pkg::EV_BLOCKED];
            if (ev_set[pickup_pkg::EV_BLOCKED]) begin
                event_q <= {stamp_q[7:0], fault_type_i, meas_i};
            end
        end
    end

    // fault register: latest trip values, cleared by input or command
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fault_q <= '0;
        end else if (ev_set[pickup_pkg::EV_TRIP]) begin
            fault_q <= {stamp_q[7:0], fault_type_i, meas_i};
        end else if (frs_q || cmd_fault_q) begin
            fault_q <= '0;
        end
    end

    // latched trip, cleared by input or command; a new trip wins
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            latched_trip_o <= 1'b0;
        end else if (ev_set[pickup_pkg::EV_TRIP]) begin
            latched_trip_o <= 1'b1;
        end else if (lrs_q || cmd_latch_q) begin
            latched_trip_o <= 1'b0;
        end
    end

    // loose outputs: phase order, recorder gate, lamps, interrupt
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            phase_acb_o <= 1'b0;
            rec_enable_o <= 1'b0;
            lamp_close_o <= 1'b0;
            lamp_open_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            phase_acb_o <= ph_q ^ ctrl_q[pickup_pkg::CTRL_PHASE_BIT];
            rec_enable_o <= ctrl_q[pickup_pkg::CTRL_REC_BIT];
            lamp_close_o <= obj_closed_i[ctrl_q[pickup_pkg::CTRL_OBJ_LSB +: 4]];
            lamp_open_o <= !obj_closed_i[ctrl_q[pickup_pkg::CTRL_OBJ_LSB +: 4]];
            irq_o <= |((int_stat_q | ev_set) & int_mask_q);
        end
    end

    // ****************************************************************
    // bus answer: one wait-free ack, unmapped reads return zero
    // ****************************************************************
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wr_en || rd_en;
            wb_dat_o <= '0;
            if (rd_en) begin
                unique case (wb_adr_i)
                    pickup_pkg::ADDR_CTRL: wb_dat_o <= ctrl_q;
                    pickup_pkg::ADDR_LEVEL: wb_dat_o <= {16'h0000, level_q};
                    pickup_pkg::ADDR_DELAY: wb_dat_o <= {13'h0000, delay_q};
                    pickup_pkg::ADDR_STATUS: wb_dat_o <= {26'h0000_000, ph_q, blk_q, pickup_q,
                                                          trip_o, blocked_o, start_o};
                    pickup_pkg::ADDR_INT_STAT: wb_dat_o <= {29'h0000_0000, int_stat_q};
                    pickup_pkg::ADDR_INT_MASK: wb_dat_o <= {29'h0000_0000, int_mask_q};
                    pickup_pkg::ADDR_EVENT: wb_dat_o <= event_q;
                    pickup_pkg::ADDR_FAULT: wb_dat_o <= fault_q;
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

endmodule

// ===== logic/step_timer.sv
`timescale 1ns/1ps
// definite time counter: counts step ticks while run_i holds
module step_timer (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic run_i,
    input wire logic [pickup_pkg::DELAY_W-1:0] steps_i,
    // result
    output logic expired_o
);

    localparam int TICK_CYC = pickup_pkg::CLK_HZ / 1_000_000 * pickup_pkg::DELAY_STEP_US;
    localparam int TICK_W = $clog2(TICK_CYC);

    logic [TICK_W-1:0] tick_q;
    logic [pickup_pkg::DELAY_W-1:0] step_q;

    // prescaler restarts with each run so the first step is a full one
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !run_i || tick_q == TICK_W'(TICK_CYC - 1)) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // step counter saturates at the set delay
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !run_i) begin
            step_q <= '0;
        end else if (tick_q == TICK_W'(TICK_CYC - 1) && step_q != steps_i) begin
            step_q <= step_q + 1'b1;
        end
    end

    // expiry is a registered level
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !run_i) begin
            expired_o <= 1'b0;
        end else begin
            expired_o <= (step_q == steps_i);
        end
    end

endmodule

// ===== sim/block_matrix_model.sv
`timescale 1ns/1ps
// blocking matrix stand-in: moves the blocking line after a chosen lag
module block_matrix_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // request from the bench
    input wire logic want_i,
    input wire logic [3:0] lag_i,
    // blocking line to the stage
    output logic block_o
);
    logic [3:0] cnt_q;
    // bench lag of at most 3 stays within the nine-cycle wait before each processing cycle so blocking always lands in time
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || want_i == block_o) begin
            cnt_q <= 4'h0;
            block_o <= sys_rst_i ? 1'b0 : block_o;
        end else if (cnt_q >= lag_i) begin
            block_o <= want_i;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// ===== sim/pickup_stage_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// port checks for the pickup stage
// ****************************************************************
module pickup_stage_assertions (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // decision path
    input wire logic cycle_start_i,
    input wire logic start_o,
    input wire logic blocked_o,
    input wire logic trip_o,
    input wire logic blocked_notify_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // a request is taken while no answer is pending
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // the answer is a single cycle pulse
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_answer: assert property (s_req |=> s_answer) else $error("bus request not answered in one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_start_blk_excl: assert property (!(start_o && blocked_o)) else $error("start and blocked together");
    a_trip_with_start: assert property (trip_o |-> start_o) else $error("trip without start");
    a_start_on_cycle: assert property ($changed(start_o) |-> $past(cycle_start_i)) else $error("start moved");
    a_blocked_on_cycle: assert property ($changed(blocked_o) |-> $past(cycle_start_i)) else $error("blocked moved");
    a_trip_on_cycle: assert property ($changed(trip_o) |-> $past(cycle_start_i)) else $error("trip moved");
    a_notify_pulse: assert property (blocked_notify_o |=> !blocked_notify_o) else $error("notify too long");
    a_notify_cause: assert property ($rose(blocked_o) |-> ##[0:1] blocked_notify_o) else $error("no notify");
endmodule
bind pickup_stage pickup_stage_assertions u_pickup_stage_assertions (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cycle_start_i(cycle_start_i),
    .start_o(start_o), .blocked_o(blocked_o), .trip_o(trip_o), .blocked_notify_o(blocked_notify_o));

// ===== sim/protection_stage_pickup_block_tb_top.sv
`timescale 1ns/1ps
module protection_stage_pickup_block_tb_top;
    // ****************************************************************
    // stimulus, model state and counters
    // ****************************************************************
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, fault_type_i = 8'h00, ft;
    logic [3:0] wb_sel_i = 4'hF, lag = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, seed = 32'hb135_82ee;
    logic [15:0] meas_i = 16'h0000, m;
    logic cycle_start_i = 1'b0, want_block = 1'b0, block_i, latch_reset_i = 1'b0, fault_reset_i = 1'b0;
    logic phase_order_i = 1'b0, edit_allow_i = 1'b0, wb_ack_o;
    logic [9:0] obj_closed_i = 10'h000;
    logic start_o, blocked_o, trip_o, latched_trip_o, blocked_notify_o, phase_acb_o, rec_enable_o;
    logic lamp_close_o, lamp_open_o, irq_o, under = 1'b0, pk = 1'b0, pb = 1'b0, b, s, dt = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [23:0] ev = 24'h00_0000;
    int n_fail = 0, checks = 0, cyc_cnt = 0, n_notify = 0, exp_notify = 0, lvl = 256;

    always #50 mclk_i = ~mclk_i;

    pickup_stage u_pickup_stage (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cycle_start_i, .meas_i, .fault_type_i, .block_i, .latch_reset_i,
        .fault_reset_i, .phase_order_i, .edit_allow_i, .obj_closed_i, .start_o, .blocked_o, .trip_o,
        .latched_trip_o, .blocked_notify_o, .phase_acb_o, .rec_enable_o, .lamp_close_o, .lamp_open_o, .irq_o);
    block_matrix_model u_block_matrix_model (.mclk_i, .sys_rst_i, .want_i(want_block), .lag_i(lag),
        .block_o(block_i));

    // cycle ceiling against hangs, and notify pulse count
    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (blocked_notify_o === 1'b1) n_notify++;
        if (cyc_cnt >= 60000) begin
            chk(cyc_cnt, 0);
            tally_and_finish();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single wishbone cycle; waits for ack without assuming latency
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) chk(n, 0);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // one processing cycle; the model decides from level, direction and blocking
    task automatic run(input logic [15:0] mv, input logic blk);
        want_block <= blk;
        lag <= 4'(rnd() % 4);
        repeat (9) @(posedge mclk_i);
        ft = 8'(rnd());
        cycle_start_i <= 1'b1;
        meas_i <= mv;
        fault_type_i <= ft;
        @(posedge mclk_i);
        cycle_start_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        b = blk | mode[0];
        if (!under) pk = pk ? !(mv * 100 < lvl * 97) : (mv > lvl);
        else pk = pk ? !(mv * 100 > lvl * 103) : (mv < lvl);
        s = pk && !b;
        if (pk && b && !pb) begin
            exp_notify++;
            ev = {ft, mv};
        end
        pb = pk && b;
        chk(32'({start_o, blocked_o, trip_o}), 32'({s, pk && b, s && !dt}));
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        #1;
        chk(32'({start_o, blocked_o, trip_o}), 32'h0000_0000);
        rdchk(pickup_pkg::ADDR_CTRL, 32'h0000_0000);
        rdchk(pickup_pkg::ADDR_LEVEL, 32'h0000_0100);
        rdchk(pickup_pkg::ADDR_DELAY, 32'h0000_0008);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0000_0000);
        wb(1'b1, pickup_pkg::ADDR_DELAY, 32'h0000_0000);
        // over then under direction, random values around the level
        for (int d = 0; d < 2; d++) begin
            under = d[0];
            wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_0008 | 32'(d));
            for (int i = 0; i < 40; i++) begin
                m = 16'(lvl - (d ? 6 : 16) + int'(rnd() % 24));
                run(m, rnd() % 3 == 0);
            end
            run(d ? 16'hFFFF : 16'h0000, 1'b0);
        end
        under = 1'b0;
        chk(32'(n_notify), 32'(exp_notify));
        wb(1'b0, pickup_pkg::ADDR_EVENT, 32'h0000_0000);
        chk(32'(rd[23:0]), 32'(ev));
        // every device mode, then a write refused while editing is barred
        edit_allow_i <= 1'b1;
        for (int md = 0; md < 4; md++) begin
            repeat (6) @(posedge mclk_i);
            wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_0008 | 32'(md << 1));
            rdchk(pickup_pkg::ADDR_CTRL, 32'h0000_0008 | 32'(md << 1));
            mode = 2'(md);
            run(16'd300, 1'b0);
            run(16'd0, 1'b0);
        end
        wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_0008);
        mode = 2'h0;
        edit_allow_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_000A);
        rdchk(pickup_pkg::ADDR_CTRL, 32'h0000_0008);
        // sticky events, mask effect and write-one-to-clear
        rdchk(pickup_pkg::ADDR_INT_STAT, 32'h0000_0007);
        wb(1'b1, pickup_pkg::ADDR_INT_MASK, 32'h0000_0000);
        repeat (2) @(posedge mclk_i);
        chk(32'(irq_o), 32'h0);
        wb(1'b1, pickup_pkg::ADDR_INT_MASK, 32'h0000_0007);
        repeat (2) @(posedge mclk_i);
        chk(32'(irq_o), 32'h1);
        wb(1'b1, pickup_pkg::ADDR_INT_STAT, 32'h0000_0007);
        rdchk(pickup_pkg::ADDR_INT_STAT, 32'h0000_0000);
        chk(32'(irq_o), 32'h0000_0000);
        // latch clearing by command and by pin, fault record clearing
        run(16'd300, 1'b0);
        run(16'd0, 1'b0);
        chk(32'(latched_trip_o), 32'h0000_0001);
        wb(1'b1, pickup_pkg::ADDR_CMD, 32'h0000_0003);
        rdchk(pickup_pkg::ADDR_CMD, 32'h0000_0000);
        chk(32'(latched_trip_o), 32'h0000_0000);
        rdchk(pickup_pkg::ADDR_FAULT, 32'h0000_0000);
        run(16'd300, 1'b0);
        run(16'd0, 1'b0);
        latch_reset_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        latch_reset_i <= 1'b0;
        chk(32'(latched_trip_o), 32'h0000_0000);
        wb(1'b0, pickup_pkg::ADDR_FAULT, 32'h0000_0000);
        chk(32'(rd[15:0]), 32'd300);
        fault_reset_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        fault_reset_i <= 1'b0;
        rdchk(pickup_pkg::ADDR_FAULT, 32'h0000_0000);
        // phase order pin, lamp object choice, recorder enable
        for (int p = 1; p >= 0; p--) begin
            phase_order_i <= p[0];
            repeat (6) @(posedge mclk_i);
            chk(32'(phase_acb_o), 32'(p));
        end
        obj_closed_i <= 10'(rnd());
        wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_0320);
        wb(1'b1, pickup_pkg::ADDR_CTRL, 32'h0000_0C20);
        rdchk(pickup_pkg::ADDR_CTRL, 32'h0000_0320);
        chk(32'({lamp_close_o, lamp_open_o, rec_enable_o}), 32'({obj_closed_i[3], !obj_closed_i[3], 1'b1}));
        wb(1'b1, pickup_pkg::ADDR_DELAY, 32'h0000_0001);
        dt = 1'b1;
        run(16'd300, 1'b0);
        dt = 1'b0;
        repeat (50010) @(posedge mclk_i);
        run(16'd300, 1'b0);
        tally_and_finish();
    end
endmodule
